// ==== logic/pin_group_pkg.sv ====
// Shared offsets, field positions and types for the pin group block
package pin_group_pkg;
    // Register byte offsets within one group
    localparam logic [6:0] OFS_DRIVE_LEVEL = 7'h10; // Output drive level, readback
    localparam logic [6:0] OFS_DRIVE_FLIP = 7'h1c; // Toggle, write ones
    localparam logic [6:0] OFS_INPUT_LEVELS = 7'h20; // Sampled pin levels
    localparam logic [6:0] OFS_SAMPLER_CTRL = 7'h24; // Sampling mode per pin
    localparam logic [6:0] OFS_GROUP_WRITER = 7'h28; // Multi-pin writer
    localparam logic [6:0] OFS_DIRECTION = 7'h00; // Pin direction, 1 = output
    localparam logic [6:0] GROUP_STRIDE = 7'h7f; // Mask for 0x80 stride within group
    // Reset values
    localparam logic [31:0] RST_INPUT_LEVELS = 32'h40000000;
    localparam logic [31:0] RST_SAMPLER_CTRL = 32'h00000000;
    localparam logic [31:0] RST_DRIVE_LEVEL = 32'h00000000;
    localparam logic [31:0] RST_DIRECTION = 32'h00000000;
    // Multi-pin writer field positions
    localparam int HALF_SELECT_BIT = 31;
    localparam int SETTINGS_UPDATE_BIT = 30;
    localparam int ROUTE_UPDATE_BIT = 28;
    localparam int FUNC_SEL_LSB = 24;
    localparam int DRIVE_STRENGTH_BIT = 22;
    localparam int PULL_ENABLE_BIT = 18;
    localparam int INPUT_BUFFER_BIT = 17;
    localparam int ROUTE_ENABLE_BIT = 16;
    localparam int HALF_PINS = 16;
    localparam int LANE_PINS = 8;
    // Per-pin settings carried together
    typedef struct packed {
        logic driveStrength; // Stronger driver when set
        logic pullEnable; // Pull resistor on
        logic inputBufferEnable; // Input buffer on
        logic periphRouteEnable; // Peripheral owns pin
    } pin_settings_t;
    // Bus request carried together
    typedef struct packed {
        logic [6:0] addr; // Byte address within group
        logic [31:0] wdata; // Write data
        logic [3:0] byteEn; // Byte enables
        logic wr; // Write strobe
        logic rd; // Read strobe
    } bus_req_t;
endpackage

// ==== logic/pin_group_ctrl.sv ====
// One 32-pin group: toggle, input sampling, sampler control, multi-pin writer
//
// Behaviour
// - Toggle one-bit inverts matching drive level
// - Toggle zero-bit leaves pin unchanged
// - Toggle on pulled input swaps pull direction
// - Input level bit follows sampled pin level
// - Control bit: 0 on-demand, 1 continuous
// - Samplers enabled per eight-pin byte lane
// - Sampling mode applies only to inputs
// - Each group has own registers, 0x80 stride
// - Multi-pin writer acts on full words only
// - Multi-pin writer always reads zero
// - One write updates all selected pins together
// - Half select picks pins 0-15 or 16-31
// - Settings update loads per-pin settings fields
// - Settings update zero leaves settings alone
// - Settings fields at bits 22,18,17,16
// - Updated pins are mask plus half select
// - Route update loads four-bit function select
// - Clear mask bit keeps pin configuration
`timescale 1ns/1ps
module pin_group_ctrl #(
    parameter int PINS = 32, // Pins in this group
    parameter int FUNC_W = 4 // Function select width
) (
    input wire logic clk,
    input wire logic rst,
    input wire pin_group_pkg::bus_req_t busReq,
    output logic [31:0] rdata,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [PINS-1:0] sampleReq,
    output logic [PINS-1:0] driveLevel,
    output logic [PINS-1:0] direction,
    output logic [PINS-1:0] driveStrength,
    output logic [PINS-1:0] pullEnable,
    output logic [PINS-1:0] inputBufferEnable,
    output logic [PINS-1:0] periphRouteEnable,
    output logic [PINS*FUNC_W-1:0] periphFunctionSelect,
    output logic [PINS/8-1:0] samplerEnable
);
    // Bus port: one request per cycle, never a read and a write together.
    // Writes land on the edge that takes them; reads answer one cycle later.
    // Only the low seven address bits matter here; the group decoder upstream
    // picks which copy of this block sees the request.
    // The direction register lives here too because sampling needs it, even
    // though its layout is not this block's concern.
    // Byte enables matter only to the multi-pin writer; every other register
    // takes the whole word.
    localparam int LANES = PINS / pin_group_pkg::LANE_PINS; // Byte lanes

    logic [6:0] offs; // Offset within the 0x80 group window
    logic [31:0] rdata_nxt; // Next read data
    logic [PINS-1:0] driveLevel_r; // Output drive level, doubles as pull direction
    logic [PINS-1:0] dir_r; // Direction, 1 = output
    logic [PINS-1:0] samplerCtrl_r; // Sampling mode bits
    logic [PINS-1:0] inLevels_r; // Sampled input levels
    logic [PINS-1:0] syncA_r; // Synchroniser first stage
    logic [PINS-1:0] syncB_r; // Synchroniser second stage
    logic [LANES-1:0] samplerEn_r; // Lane sampler enables
    pin_group_pkg::pin_settings_t [PINS-1:0] settings_r; // Per-pin settings
    logic [FUNC_W-1:0] funcSel_r [PINS]; // Per-pin function select
    logic fullWord; // All four byte lanes written
    logic writerHit; // Accepted multi-pin write
    logic [PINS-1:0] selMask; // Pins chosen by a multi-pin write
    pin_group_pkg::pin_settings_t newSettings; // Settings carried by the write

    // Group window: upper address bits belong to the group decoder outside
    assign offs = busReq.addr & pin_group_pkg::GROUP_STRIDE;

    // Drive level: toggles flip only written ones
    // The same bit doubles as pull direction on a pulled input, so one
    // toggle serves both uses without knowing the pin's direction.
    // A plain level write and a toggle cannot meet in one cycle.
    // Toggle wins the priority only for clarity; the bus never sends both.
    always_ff @(posedge clk)
    begin
        if (rst)
            driveLevel_r <= pin_group_pkg::RST_DRIVE_LEVEL;
        else if (busReq.wr && offs == pin_group_pkg::OFS_DRIVE_FLIP)
            driveLevel_r <= driveLevel_r ^ busReq.wdata;
        else if (busReq.wr && offs == pin_group_pkg::OFS_DRIVE_LEVEL)
            driveLevel_r <= busReq.wdata;
    end

    // Direction register, kept here since sampling depends on it
    // Reset leaves every pin an input, the safe state for an unknown board.
    // Written whole; set, clear and toggle views belong elsewhere.
    always_ff @(posedge clk)
    begin
        if (rst)
            dir_r <= pin_group_pkg::RST_DIRECTION;
        else if (busReq.wr && offs == pin_group_pkg::OFS_DIRECTION)
            dir_r <= busReq.wdata;
    end

    // Sampling mode control
    // One bit per pin; the lane logic below reduces them to four enables.
    // Bits of output pins are kept but have no effect until the pin
    // turns back into an input.
    always_ff @(posedge clk)
    begin
        if (rst)
            samplerCtrl_r <= pin_group_pkg::RST_SAMPLER_CTRL;
        else if (busReq.wr && offs == pin_group_pkg::OFS_SAMPLER_CTRL)
            samplerCtrl_r <= busReq.wdata;
    end

    // Lane enables: any input pin asking continuous turns the lane on
    // Registered so samplerEnable comes straight from a flop; the cost
    // is one cycle of lag after a control or direction write.
    // Lanes rather than pins, since the samplers switch eight at a time.
    // A single continuous pin therefore keeps its seven neighbours live too.
    generate
        for (genvar l = 0; l < LANES; l++)
        begin : gLane
            always_ff @(posedge clk)
            begin
                if (rst)
                    samplerEn_r[l] <= 1'b0;
                else
                    samplerEn_r[l] <= |(samplerCtrl_r[l*8 +: 8] & ~dir_r[l*8 +: 8]);
            end
        end
    endgenerate

    // Pin synchroniser, second stage is the only reader of the first
    // Pins are asynchronous to the bus clock, hence two stages.
    // Adds two cycles of latency before any level is seen.
    // Reset to zero; the reset value of the level register hides that.
    // Glitches shorter than a clock period may be missed entirely.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            syncA_r <= '0;
            syncB_r <= '0;
        end
        else
        begin
            syncA_r <= pinIn;
            syncB_r <= syncA_r;
        end
    end

    // Input levels: continuous lanes every cycle, others on demand
    // On-demand pins update only on a sampleReq pulse, so between pulses
    // software reads the level captured at the last request.
    // The reset value keeps its one set at bit 30, although the
    // pin itself has not yet been seen.
    generate
        for (genvar p = 0; p < PINS; p++)
        begin : gSample
            always_ff @(posedge clk)
            begin
                if (rst)
                    inLevels_r[p] <= pin_group_pkg::RST_INPUT_LEVELS[p];
                else if (samplerEn_r[p/8] || sampleReq[p])
                    inLevels_r[p] <= syncB_r[p];
            end
        end
    endgenerate

    // Multi-pin writer decode: byte and half-word writes are dropped
    // Atomic by design: a split write could update half a pin's settings.
    // The half select picks the sixteen pins that the mask addresses,
    // so a single write never reaches both halves.
    // Field positions come from the package so bus and checks agree.
    assign fullWord = &busReq.byteEn;
    assign writerHit = busReq.wr && offs == pin_group_pkg::OFS_GROUP_WRITER && fullWord;
    assign selMask = busReq.wdata[pin_group_pkg::HALF_SELECT_BIT]
        ? {busReq.wdata[15:0], 16'h0000}
        : {16'h0000, busReq.wdata[15:0]};
    assign newSettings = '{driveStrength: busReq.wdata[pin_group_pkg::DRIVE_STRENGTH_BIT],
        pullEnable: busReq.wdata[pin_group_pkg::PULL_ENABLE_BIT],
        inputBufferEnable: busReq.wdata[pin_group_pkg::INPUT_BUFFER_BIT],
        periphRouteEnable: busReq.wdata[pin_group_pkg::ROUTE_ENABLE_BIT]};

    // Per-pin settings and function select, all selected pins in one edge
    // Settings and function select update independently; one write may
    // carry either, both or neither, and pins outside the mask hold.
    // The writer itself keeps nothing, so it reads back as zero.
    generate
        for (genvar p = 0; p < PINS; p++)
        begin : gCfg
            always_ff @(posedge clk)
            begin
                if (rst)
                    settings_r[p] <= '0;
                else if (writerHit && selMask[p]
                    && busReq.wdata[pin_group_pkg::SETTINGS_UPDATE_BIT])
                    settings_r[p] <= newSettings;
            end
            always_ff @(posedge clk)
            begin
                if (rst)
                    funcSel_r[p] <= '0;
                else if (writerHit && selMask[p]
                    && busReq.wdata[pin_group_pkg::ROUTE_UPDATE_BIT])
                    funcSel_r[p] <= busReq.wdata[pin_group_pkg::FUNC_SEL_LSB +: FUNC_W];
            end
            assign driveStrength[p] = settings_r[p].driveStrength;
            assign pullEnable[p] = settings_r[p].pullEnable;
            assign inputBufferEnable[p] = settings_r[p].inputBufferEnable;
            assign periphRouteEnable[p] = settings_r[p].periphRouteEnable;
            assign periphFunctionSelect[p*FUNC_W +: FUNC_W] = funcSel_r[p];
        end
    endgenerate

    // Read mux; writer and unmapped offsets read zero
    // Toggle offset reads the drive level rather than zero, so software
    // can read back after a toggle without another address.
    // Everything not listed, the writer included, reads as zero.
    always_comb
    begin
        unique case (offs)
            pin_group_pkg::OFS_DIRECTION: rdata_nxt = dir_r;
            pin_group_pkg::OFS_DRIVE_LEVEL: rdata_nxt = driveLevel_r;
            pin_group_pkg::OFS_DRIVE_FLIP: rdata_nxt = driveLevel_r;
            pin_group_pkg::OFS_INPUT_LEVELS: rdata_nxt = inLevels_r;
            pin_group_pkg::OFS_SAMPLER_CTRL: rdata_nxt = samplerCtrl_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data stands one cycle after the strobe only
    // Zero outside the answer cycle keeps a stale word off the bus,
    // which also lets a wired-or of several groups work.
    // Costs one 32-bit register; the slave never stalls the master.
    // Read has no side effects, so a repeated read is harmless.
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 32'h00000000;
        else if (busReq.rd)
            rdata <= rdata_nxt;
        else
            rdata <= 32'h00000000;
    end

    // Outputs are the registers themselves, no logic after the flops,
    // so the pad ring sees clean edges.
    assign driveLevel = driveLevel_r;
    assign direction = dir_r;
    assign samplerEnable = samplerEn_r;

    // Checks, grouped by concern; all sample on the bus clock and sleep in reset
    // The commonest first steps are named sequences; every property reads
    // as the cause on one edge and the effect on the following edge.
    // Apart from rdata they look at internal registers, not ports, so a broken output wire
    // would slip past them; the bench covers the ports.

    // Toggle write seen on the bus
    sequence seqFlipWrite;
        busReq.wr && offs == pin_group_pkg::OFS_DRIVE_FLIP;
    endsequence

    // Accepted multi-pin write that carries a settings update
    sequence seqSettingsWrite;
        writerHit && busReq.wdata[pin_group_pkg::SETTINGS_UPDATE_BIT];
    endsequence

    // Accepted multi-pin write that carries a function select update
    sequence seqRouteWrite;
        writerHit && busReq.wdata[pin_group_pkg::ROUTE_UPDATE_BIT];
    endsequence

    // Read strobe aimed at the multi-pin writer
    sequence seqWriterRead;
        busReq.rd && offs == pin_group_pkg::OFS_GROUP_WRITER;
    endsequence

    // Toggle flips exactly the ones written; zeros keep their level
    AST_FLIP: assert property (@(posedge clk) disable iff (rst)
        seqFlipWrite |=> driveLevel_r == ($past(driveLevel_r) ^ $past(busReq.wdata)))
        else $error("toggle result wrong");

    // Toggle never touches direction, so a flipped pin stays where it was
    AST_FLIP_DIR: assert property (@(posedge clk) disable iff (rst)
        seqFlipWrite |=> $stable(dir_r))
        else $error("toggle changed direction");

    // Writer has no storage behind it; reads must not leak the last write
    AST_WRITER_READ: assert property (@(posedge clk) disable iff (rst)
        seqWriterRead |=> rdata == 32'h00000000)
        else $error("writer read not zero");

    // Partial writes could split an update, so the settings stay unchanged
    AST_PARTIAL: assert property (@(posedge clk) disable iff (rst)
        busReq.wr && !fullWord |=> $stable(settings_r))
        else $error("partial write changed settings");

    // Without the settings update bit the settings stay as they were
    AST_NOUPD: assert property (@(posedge clk) disable iff (rst)
        writerHit && !busReq.wdata[pin_group_pkg::SETTINGS_UPDATE_BIT] |=> $stable(settings_r))
        else $error("settings changed without update");

    // Upper half chosen: the lower sixteen pins keep their settings
    AST_HALF_UPPER: assert property (@(posedge clk) disable iff (rst)
        seqSettingsWrite ##0 busReq.wdata[pin_group_pkg::HALF_SELECT_BIT] |=> $stable(settings_r[15:0]))
        else $error("upper half write reached lower pins");

    // Lower half chosen: the upper sixteen pins keep their settings
    AST_HALF_LOWER: assert property (@(posedge clk) disable iff (rst)
        seqSettingsWrite ##0 !busReq.wdata[pin_group_pkg::HALF_SELECT_BIT] |=> $stable(settings_r[PINS-1:16]))
        else $error("lower half write reached upper pins");

    // Sampling control takes the written word on the next edge
    AST_SAMPLER_CTRL: assert property (@(posedge clk) disable iff (rst)
        busReq.wr && offs == pin_group_pkg::OFS_SAMPLER_CTRL |=> samplerCtrl_r == $past(busReq.wdata))
        else $error("sampler control not written");

    // Input level read returns the levels held when the strobe came
    AST_LEVEL_READ: assert property (@(posedge clk) disable iff (rst)
        busReq.rd && offs == pin_group_pkg::OFS_INPUT_LEVELS |=> rdata == $past(inLevels_r))
        else $error("input level read wrong");

    // Second synchroniser stage copies the first, one edge late
    AST_SYNC: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> syncB_r == $past(syncA_r))
        else $error("synchroniser stage skipped");

    // Lane checks, one copy per byte lane
    // A lane follows its input pins' requests one edge late
    generate
        for (genvar l = 0; l < LANES; l++)
        begin : gLaneChk
            // Continuous request from an input pin switches the lane on
            AST_LANE_ON: assert property (@(posedge clk) disable iff (rst)
                |(samplerCtrl_r[l*8 +: 8] & ~dir_r[l*8 +: 8]) |=> samplerEn_r[l])
                else $error("lane not switched on");
            // Requests from output pins alone leave the lane off
            AST_LANE_OFF: assert property (@(posedge clk) disable iff (rst)
                !(|(samplerCtrl_r[l*8 +: 8] & ~dir_r[l*8 +: 8])) |=> !samplerEn_r[l])
                else $error("lane on without input request");
        end
    endgenerate

    // Per-pin checks, one copy per pin
    generate
        for (genvar p = 0; p < PINS; p++)
        begin : gPinChk
            // Selected pin takes the written settings together with the others
            AST_CFG_LOAD: assert property (@(posedge clk) disable iff (rst)
                seqSettingsWrite ##0 selMask[p] |=> settings_r[p] == $past(newSettings))
                else $error("selected pin settings not loaded");
            // A pin outside mask and half keeps settings and function select
            AST_CFG_KEEP: assert property (@(posedge clk) disable iff (rst)
                !(writerHit && selMask[p]) |=> $stable(settings_r[p]) && $stable(funcSel_r[p]))
                else $error("unselected pin changed");
            // Route update loads the four-bit select of a selected pin
            AST_ROUTE_LOAD: assert property (@(posedge clk) disable iff (rst)
                seqRouteWrite ##0 selMask[p] |=>
                funcSel_r[p] == $past(busReq.wdata[pin_group_pkg::FUNC_SEL_LSB +: FUNC_W]))
                else $error("function select not loaded");
            // Without the route update bit the function select holds
            AST_ROUTE_NOUPD: assert property (@(posedge clk) disable iff (rst)
                writerHit && !busReq.wdata[pin_group_pkg::ROUTE_UPDATE_BIT] |=> $stable(funcSel_r[p]))
                else $error("function select changed without update");
            // Sampled pin copies the synchroniser output on the next edge
            AST_SAMPLE: assert property (@(posedge clk) disable iff (rst)
                samplerEn_r[p / pin_group_pkg::LANE_PINS] || sampleReq[p] |=>
                inLevels_r[p] == $past(syncB_r[p]))
                else $error("input level not sampled");
            // On-demand pin without a request holds its last level
            AST_HOLD: assert property (@(posedge clk) disable iff (rst)
                !samplerEn_r[p / pin_group_pkg::LANE_PINS] && !sampleReq[p] |=> $stable(inLevels_r[p]))
                else $error("input level changed without sampling");
            // Toggle on a pulled input swaps its pull direction
            AST_PULL_FLIP: assert property (@(posedge clk) disable iff (rst)
                seqFlipWrite ##0 (busReq.wdata[p] && !dir_r[p] && settings_r[p].pullEnable) |=>
                driveLevel_r[p] != $past(driveLevel_r[p]))
                else $error("pull direction not swapped");
        end
    endgenerate
endmodule

// ==== verification/pin_drive_model.sv ====
// Pin-side partner: outside drivers, output loopback and pull levels
`timescale 1ns/1ps
module pin_drive_model (
    input wire logic [31:0] direction,
    input wire logic [31:0] driveLevel,
    input wire logic [31:0] pullEnable,
    input wire logic [31:0] extLevel,
    input wire logic [31:0] extDrive,
    output logic [31:0] pinIn
);
    // Own driver wins, then outside driver, then pull; a floating pin never repeats a level
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (direction[i])
                pinIn[i] = driveLevel[i];
            else if (extDrive[i])
                pinIn[i] = extLevel[i];
            else if (pullEnable[i])
                pinIn[i] = driveLevel[i];
            else
                pinIn[i] = ~driveLevel[i];
        end
    end
endmodule

// ==== verification/tb_io_port_toggle_sample_multicfg.sv ====
// Self-checking bench for the pin group block
`timescale 1ns/1ps
module tb_io_port_toggle_sample_multicfg;
    logic clk = 1'b0; // 40 MHz bus clock
    logic rst = 1'b1; // Held for six cycles
    pin_group_pkg::bus_req_t busReq = '0; // Bus master request
    logic [31:0] extLevel = 32'h1234abcd; // Outside pin levels
    logic [31:0] extDrive = 32'hffffffff; // Outside drivers on
    logic [31:0] sampleReq = 32'h0; // On-demand sample pulses
    logic [31:0] rdata, pinIn, driveLevel, direction, driveStrength, pullEnable;
    logic [31:0] inputBufferEnable, periphRouteEnable;
    logic [127:0] periphFunctionSelect, fsExp;
    logic [3:0] samplerEnable;
    int failures = 0;
    int nChecks = 0;
    // Clock
    always #12.5 clk = ~clk;
    pin_group_ctrl pin_group_ctrl_i (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
        .pinIn(pinIn), .sampleReq(sampleReq), .driveLevel(driveLevel), .direction(direction),
        .driveStrength(driveStrength), .pullEnable(pullEnable),
        .inputBufferEnable(inputBufferEnable), .periphRouteEnable(periphRouteEnable),
        .periphFunctionSelect(periphFunctionSelect), .samplerEnable(samplerEnable));
    pin_drive_model pin_drive_model_i (.direction(direction), .driveLevel(driveLevel),
        .pullEnable(pullEnable), .extLevel(extLevel), .extDrive(extDrive), .pinIn(pinIn));
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        nChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, byteEn: be, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [6:0] a, input logic [31:0] exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 32'h0, byteEn: 4'hf, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        rchk("inputLevels", pin_group_pkg::OFS_INPUT_LEVELS, 32'h40000000);
        rchk("samplerCtrl", pin_group_pkg::OFS_SAMPLER_CTRL, 32'h0);
        rchk("writerRead", pin_group_pkg::OFS_GROUP_WRITER, 32'h0);
        rchk("unmapped", 7'h7c, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_toggle();
        wr(pin_group_pkg::OFS_DIRECTION, 32'hffff0000, 4'hf);
        wr(pin_group_pkg::OFS_DRIVE_FLIP, 32'h0000a5a5, 4'hf);
        idle(1);
        chk("driveLevel", 32'h0000a5a5, driveLevel);
        wr(pin_group_pkg::OFS_DRIVE_FLIP, 32'h00000005, 4'hf);
        idle(1);
        chk("driveLevel", 32'h0000a5a0, driveLevel);
        chk("direction", 32'hffff0000, direction);
        $display("test toggle done");
    endtask
    task automatic t_sample();
        wr(pin_group_pkg::OFS_DIRECTION, 32'h0, 4'hf);
        wr(pin_group_pkg::OFS_SAMPLER_CTRL, 32'h00000100, 4'hf);
        idle(4);
        chk("samplerEnable", 4'b0010, samplerEnable);
        rchk("inputLevels", pin_group_pkg::OFS_INPUT_LEVELS, 32'h4000ab00);
        @(posedge clk);
        sampleReq <= 32'h000000ff;
        @(posedge clk);
        sampleReq <= 32'h0;
        idle(4);
        rchk("inputLevels", pin_group_pkg::OFS_INPUT_LEVELS, 32'h4000abcd);
        wr(pin_group_pkg::OFS_DIRECTION, 32'h0000ff00, 4'hf);
        idle(4);
        chk("samplerEnable", 4'b0000, samplerEnable);
        rchk("inputLevels", pin_group_pkg::OFS_INPUT_LEVELS, 32'h4000abcd);
        $display("test sample done");
    endtask
    task automatic t_writer();
        wr(pin_group_pkg::OFS_GROUP_WRITER, 32'hd7458001, 4'h3);
        idle(1);
        chk("driveStrength", 32'h0, driveStrength);
        wr(pin_group_pkg::OFS_GROUP_WRITER, 32'hd7458001, 4'hf);
        idle(1);
        chk("driveStrength", 32'h80010000, driveStrength);
        chk("pullEnable", 32'h80010000, pullEnable);
        chk("inputBufferEnable", 32'h0, inputBufferEnable);
        chk("periphRouteEnable", 32'h80010000, periphRouteEnable);
        fsExp = '0;
        fsExp[64+:4] = 4'h7;
        fsExp[124+:4] = 4'h7;
        chk("functionSelect", fsExp, periphFunctionSelect);
        wr(pin_group_pkg::OFS_GROUP_WRITER, 32'h0040ffff, 4'hf);
        idle(1);
        chk("driveStrength", 32'h80010000, driveStrength);
        wr(pin_group_pkg::OFS_GROUP_WRITER, 32'h13000002, 4'hf);
        idle(1);
        fsExp[4+:4] = 4'h3;
        chk("functionSelect", fsExp, periphFunctionSelect);
        chk("periphRouteEnable", 32'h80010000, periphRouteEnable);
        rchk("writerRead", pin_group_pkg::OFS_GROUP_WRITER, 32'h0);
        // Pin 31 is a pulled input now, so the flip swaps its pull direction
        wr(pin_group_pkg::OFS_DRIVE_FLIP, 32'h80000000, 4'hf);
        idle(1);
        chk("driveLevel", 32'h8000a5a0, driveLevel);
        $display("test writer done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_toggle();
        t_sample();
        t_writer();
        end_of_test();
    end
    // Watchdog at 4000 cycles, far beyond the 65 or so cycles the tests need
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule
